// ### tcrd_pkg.sv
/*
  Shared constants for the two-wire command read block: bus addresses,
  command codes, clock register layout and bit counts.
  Assumes nothing of its surroundings; imported by tcrd_clk_mem, tcrd_top and tcrd_top_tb.
*/
package tcrd_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h4F;
  localparam logic [7:0] ADDR_WR = 8'h9E;
  localparam logic [7:0] ADDR_RD = 8'h9F;
  localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
  localparam logic [7:0] CMD_ACCESS_CLOCK = 8'hC0;
  localparam logic [7:0] CMD_ACCESS_CONFIG = 8'hAC;
  localparam logic [2:0] CLK_ADDR_SECONDS = 3'h0;
  localparam logic [2:0] CLK_ADDR_MINUTES = 3'h1;
  localparam logic [2:0] CLK_ADDR_LAST = 3'h6;
  localparam int CLK_REGS = 7;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [0:0] BYTE_HIGH = 1'h0;
  localparam logic [0:0] BYTE_LOW = 1'h1;
  typedef enum logic [2:0] {
    TCRD_IDLE, TCRD_ADDR, TCRD_CMD, TCRD_PTR, TCRD_WDATA, TCRD_RDATA, TCRD_SKIP
  } tcrd_state_e;
endpackage : tcrd_pkg

// ### tcrd_clk_if.sv
/*
  Interface carrying clock register reads between the link logic and the
  clock register store.
  Assumes both ends run on the link clock.
*/
`timescale 1ns/1ps
interface tcrd_clk_if;
  logic [2:0] rd_addr;
  logic [7:0] rd_data;
  modport link(output rd_addr, input rd_data);
  modport store(input rd_addr, output rd_data);
endinterface : tcrd_clk_if

// ### tcrd_clk_mem.sv
/*
  Clock register store: seven bytes mirrored from the system clock domain
  into the link domain, read data out of a register.
  Assumes the system side values change slowly compared with a byte time.
*/
`timescale 1ns/1ps
module tcrd_clk_mem
  import tcrd_pkg::*;
(
  // Link side
  input wire logic i_clk,
  input wire logic i_rst_n,
  tcrd_clk_if.store rd,
  // Values from the clock counters
  input wire logic [8*CLK_REGS-1:0] i_values
);
  logic [7:0] mem_reg [CLK_REGS];
  logic [7:0] data_reg;
  // The store is refreshed every link edge; a byte is latched whole so a
  // byte on the wire never mixes two counter values.
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < CLK_REGS; i++) begin
      mem_reg[i] <= i_values[8*i +: 8];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      data_reg <= 8'h00;
    end else begin
      data_reg <= mem_reg[rd.rd_addr];
    end
  end
  assign rd.rd_data = data_reg;
endmodule : tcrd_clk_mem

// ### tcrd_bitsync.sv
/*
  Two flip-flop synchroniser for a bundle of levels.
  Assumes inputs are quasi-static across several destination clocks.
*/
`timescale 1ns/1ps
module tcrd_bitsync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  always_ff @(posedge i_clk) begin
    s1_reg <= i_d;
    s2_reg <= s1_reg;
  end
  assign o_q = s2_reg;
endmodule : tcrd_bitsync

// ### tcrd_top.sv
/*
  Read side command handling of a thermometer and clock slave on a two-wire
  bus. The link logic runs on SCL sampled by I_CLK after synchronisation;
  the source values come from the system domain as levels.
  Assumes an external pad resolves SDA from O_SDA_OE (drive low when high).
*/
`timescale 1ns/1ps
// Functional notes
// - The device acknowledges its address byte and every command or pointer byte.
// - Command AAh followed by a repeated start and read returns the temperature.
// - Temperature is sent high byte first then low byte, each MSB first.
// - Command C0h followed by one byte loads the clock register pointer.
// - Clock address 01h holds minutes, so reads starting there give minutes first.
// - During a clock read the pointer advances after every acknowledged byte.
// - Command ACh followed by a read returns the two configuration bytes.
// - Configuration is sent high byte first, then the low byte with alarm flags.
// - The clock pointer wraps from the highest address to the lowest after its ACK.
module tcrd_top
  import tcrd_pkg::*;
(
  // System clock and control
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  // Two-wire bus pins
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // Values to report
  input wire logic [15:0] I_TEMP,
  input wire logic [15:0] I_CONFIG,
  input wire logic [8*CLK_REGS-1:0] I_CLOCK_VALUES,
  // Status
  output logic O_BUSY,
  output logic [7:0] O_COMMAND
);
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  tcrd_state_e state_reg;
  tcrd_state_e state_next;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] cmd_reg;
  logic [2:0] ptr_reg;
  logic byte_sel_reg;
  logic rw_reg;
  logic drive_reg;
  logic [7:0] tx_reg;
  logic [15:0] temp_s;
  logic [15:0] config_s;
  tcrd_clk_if clk_bus();

  tcrd_bitsync #(.W(2)) u_pin_sync (
    .i_clk(I_CLK),
    .i_d({I_SCL, I_SDA}),
    .o_q({scl_s, sda_s})
  );
  tcrd_bitsync #(.W(32)) u_val_sync (
    .i_clk(I_CLK),
    .i_d({I_TEMP, I_CONFIG}),
    .o_q({temp_s, config_s})
  );
  tcrd_clk_mem u_clk_mem (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .rd(clk_bus.store),
    .i_values(I_CLOCK_VALUES)
  );

  wire scl_rise = scl_s && !scl_d_reg;
  wire scl_fall = !scl_s && scl_d_reg;
  wire start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  wire stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
  wire byte_done = scl_rise && (bit_reg == BIT_LAST);
  wire ack_clock = scl_rise && (bit_reg == BIT_ACK);
  wire master_ack = ack_clock && !sda_s;
  // By the ACK slot the whole byte sits in shift_reg; rx_byte is already one bit on.
  wire addr_match = (shift_reg[7:1] == DEV_ADDR);
  wire is_clock_cmd = (cmd_reg == CMD_ACCESS_CLOCK);

  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = (p == CLK_ADDR_LAST) ? CLK_ADDR_SECONDS : 3'(p + 3'h1);
  endfunction : ptr_inc

  // Next byte source: temperature, configuration or the clock store.
  logic [7:0] src_byte;
  always_comb begin
    src_byte = 8'hFF;
    case (cmd_reg)
      CMD_READ_TEMP: src_byte = byte_sel_reg ? temp_s[7:0] : temp_s[15:8];
      CMD_ACCESS_CONFIG: src_byte = byte_sel_reg ? config_s[7:0] : config_s[15:8];
      CMD_ACCESS_CLOCK: src_byte = clk_bus.rd_data;
      default: src_byte = 8'hFF;
    endcase
  end
  assign clk_bus.rd_addr = ptr_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TCRD_IDLE: state_next = TCRD_IDLE;
      TCRD_ADDR: begin
        if (ack_clock) begin
          if (!drive_reg) begin
            state_next = TCRD_SKIP;
          end else if (rw_reg) begin
            state_next = TCRD_RDATA;
          end else begin
            state_next = TCRD_CMD;
          end
        end
      end
      TCRD_CMD: begin
        if (ack_clock) begin
          state_next = is_clock_cmd ? TCRD_PTR : TCRD_WDATA;
        end
      end
      TCRD_PTR: begin
        if (ack_clock) begin
          state_next = TCRD_WDATA;
        end
      end
      TCRD_WDATA: state_next = TCRD_WDATA;
      TCRD_RDATA: begin
        if (ack_clock && sda_s) begin
          state_next = TCRD_SKIP;
        end
      end
      TCRD_SKIP: state_next = TCRD_SKIP;
      default: state_next = TCRD_IDLE;
    endcase
    if (start_cond) begin
      state_next = TCRD_ADDR;
    end else if (stop_cond) begin
      state_next = TCRD_IDLE;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (I_CE) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_reg <= TCRD_IDLE;
    end else if (I_CE) begin
      state_reg <= state_next;
    end
  end

  // Bit counter: 0..7 data bits, 8 acknowledge slot, restarts on start.
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      bit_reg <= 4'h0;
    end else if (I_CE) begin
      if (start_cond) begin
        bit_reg <= 4'h0;
      end else if (ack_clock) begin
        bit_reg <= 4'h0;
      end else if (scl_rise) begin
        bit_reg <= 4'(bit_reg + 4'h1);
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      shift_reg <= 8'h00;
    end else if (I_CE && scl_rise && bit_reg < BIT_ACK) begin
      shift_reg <= rx_byte;
    end
  end

  // Command context: a stop forgets it, so a later read without a fresh
  // command returns idle-high bytes rather than stale data.
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      cmd_reg <= 8'h00;
      rw_reg <= 1'b0;
    end else if (I_CE) begin
      if (stop_cond) begin
        cmd_reg <= 8'h00;
      end else if (byte_done && state_reg == TCRD_ADDR) begin
        rw_reg <= rx_byte[0];
      end else if (byte_done && state_reg == TCRD_CMD) begin
        cmd_reg <= rx_byte;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ptr_reg <= CLK_ADDR_MINUTES;
      byte_sel_reg <= BYTE_HIGH;
    end else if (I_CE) begin
      if (byte_done && state_reg == TCRD_CMD) begin
        byte_sel_reg <= BYTE_HIGH;
      end else if (byte_done && state_reg == TCRD_PTR) begin
        ptr_reg <= (rx_byte > {5'h00, CLK_ADDR_LAST}) ? CLK_ADDR_SECONDS : rx_byte[2:0];
      end else if (start_cond) begin
        byte_sel_reg <= BYTE_HIGH;
      end else if (state_reg == TCRD_RDATA && master_ack) begin
        byte_sel_reg <= BYTE_LOW;
        if (is_clock_cmd) begin
          ptr_reg <= ptr_inc(ptr_reg);
        end
      end
    end
  end

  // SDA drive: ACK slots of address, command and pointer bytes, data bits in read bytes. Changes on
  // SCL falling edges, and is released on a start or stop, so data is stable while SCL is high.
  wire [3:0] bit_after = (bit_reg == BIT_ACK) ? 4'h0 : bit_reg;
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      drive_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else if (I_CE) begin
      if (start_cond || stop_cond) begin
        drive_reg <= 1'b0;
      end else if (scl_fall) begin
        if (bit_reg == BIT_ACK && state_reg == TCRD_ADDR) begin
          drive_reg <= addr_match;
        end else if (bit_reg == BIT_ACK && (state_reg == TCRD_CMD || state_reg == TCRD_PTR)) begin
          drive_reg <= 1'b1;
        end else if (state_reg == TCRD_RDATA && bit_reg == 4'h0) begin
          tx_reg <= {src_byte[6:0], 1'b1};
          drive_reg <= !src_byte[7];
        end else if (state_reg == TCRD_RDATA && bit_after < BIT_ACK) begin
          tx_reg <= {tx_reg[6:0], 1'b1};
          drive_reg <= !tx_reg[7];
        end else begin
          drive_reg <= 1'b0;
        end
      end
    end
  end

  assign O_SDA = 1'b0;
  assign O_SDA_OE = drive_reg;
  assign O_BUSY = (state_reg != TCRD_IDLE);
  assign O_COMMAND = cmd_reg;

  chk_addr_ack: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && scl_fall && bit_reg == BIT_ACK && state_reg == TCRD_ADDR && addr_match) |=> O_SDA_OE)
    else $error("address byte not acknowledged");
  chk_cmd_ack: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && scl_fall && bit_reg == BIT_ACK && state_reg == TCRD_CMD) |=> O_SDA_OE)
    else $error("command byte not acknowledged");
  chk_ptr_load: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && byte_done && state_reg == TCRD_PTR && rx_byte <= {5'h00, CLK_ADDR_LAST}) |=> ptr_reg == $past(rx_byte[2:0]))
    else $error("clock pointer not loaded");
  chk_ptr_wrap: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && state_reg == TCRD_RDATA && master_ack && is_clock_cmd && ptr_reg == CLK_ADDR_LAST)
    |=> ptr_reg == CLK_ADDR_SECONDS)
    else $error("clock pointer did not wrap");
  chk_ptr_step: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && state_reg == TCRD_RDATA && master_ack && is_clock_cmd && ptr_reg < CLK_ADDR_LAST)
    |=> ptr_reg == $past(ptr_reg) + 3'h1)
    else $error("clock pointer did not advance");
  chk_stop_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && stop_cond) |=> (cmd_reg == 8'h00 && state_reg == TCRD_IDLE && !O_SDA_OE))
    else $error("stop did not clear context");
  chk_temp_msb: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && scl_fall && state_reg == TCRD_RDATA && bit_reg == 4'h0 && cmd_reg == CMD_READ_TEMP
     && byte_sel_reg == BYTE_HIGH) |=> O_SDA_OE == !$past(temp_s[15]))
    else $error("temperature msb bit wrong");
  chk_cfg_low: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && state_reg == TCRD_RDATA && master_ack && cmd_reg == CMD_ACCESS_CONFIG)
    |=> byte_sel_reg == BYTE_LOW)
    else $error("configuration low byte not selected");
  chk_nack_end: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && state_reg == TCRD_RDATA && ack_clock && sda_s && !start_cond && !stop_cond)
    |=> state_reg == TCRD_SKIP)
    else $error("nack did not end read");
  chk_ack_release: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && scl_fall && state_reg == TCRD_RDATA && bit_reg == BIT_ACK) |=> !O_SDA_OE)
    else $error("master ack slot not released");
  cov_temp_read: cover property (@(posedge I_CLK) state_reg == TCRD_RDATA && cmd_reg == CMD_READ_TEMP);
  cov_clock_read: cover property (@(posedge I_CLK) state_reg == TCRD_RDATA && is_clock_cmd);
  cov_cfg_read: cover property (@(posedge I_CLK) state_reg == TCRD_RDATA && cmd_reg == CMD_ACCESS_CONFIG);
  cov_ptr_wrap: cover property (@(posedge I_CLK) master_ack && is_clock_cmd && ptr_reg == CLK_ADDR_LAST);
  cov_foreign: cover property (@(posedge I_CLK) state_reg == TCRD_ADDR && ack_clock && !drive_reg);
endmodule : tcrd_top

// ### tcrd_master_model.sv
/*
  Bus master model for the two-wire read block: START, STOP and byte tasks.
  Assumes a pull-up on SDA and that the bench resolves the wire from all drivers.
*/
`timescale 1ns/1ps
module tcrd_master_model (
  // Clock and bus
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  localparam int QUARTER = 16;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Sixteen system clocks a quarter keeps the bus period above 2.5 us.
  task automatic wait_q;
    repeat (QUARTER) @(posedge i_clk);
  endtask : wait_q
  // Raising SDA while SCL is low first makes this serve as a repeated START too.
  task automatic start_cond;
    o_sda_low <= 1'b0;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    o_sda_low <= 1'b1;
    wait_q();
    o_scl <= 1'b0;
    wait_q();
  endtask : start_cond
  task automatic stop_cond;
    o_sda_low <= 1'b1;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    o_sda_low <= 1'b0;
    wait_q();
  endtask : stop_cond
  task automatic send_bit(input logic b, output logic r);
    o_sda_low <= !b;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    r = i_sda;
    wait_q();
    o_scl <= 1'b0;
    wait_q();
  endtask : send_bit
  // The ninth bit is released for a device ACK, or is the master's ACK or NACK.
  task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic r9);
    for (int i = 7; i >= 0; i--) send_bit(d[i], q[i]);
    send_bit(nine, r9);
  endtask : xfer
endmodule : tcrd_master_model

// ### tcrd_top_tb.sv
/*
  Self-checking bench for the two-wire command read block.
  Assumes the master model drives SCL and SDA; SDA has a pull-up.
*/
`timescale 1ns/1ps
module tcrd_top_tb;
  import tcrd_pkg::*;
  logic i_clk, i_rst_n, scl, m_low, sda_w, o_sda, o_sda_oe, o_busy;
  logic [7:0] o_command, q;
  logic [15:0] temp, cfg;
  logic [8*CLK_REGS-1:0] clkv;
  logic a;
  int err_count = 0;
  int total_checks = 0;
  assign sda_w = (m_low || (o_sda_oe && !o_sda)) ? 1'b0 : 1'b1;
  tcrd_master_model m (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(m_low));
  tcrd_top uut (.I_CLK(i_clk), .I_RST_N(i_rst_n), .I_CE(1'b1), .I_SCL(scl), .I_SDA(sda_w),
    .O_SDA(o_sda), .O_SDA_OE(o_sda_oe), .I_TEMP(temp), .I_CONFIG(cfg),
    .I_CLOCK_VALUES(clkv), .O_BUSY(o_busy), .O_COMMAND(o_command));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic [7:0] dq;
    logic r;
    m.xfer(d, 1'b1, dq, r);
    ack = !r;
  endtask : wr_byte
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    m.xfer(8'hFF, !more, d, r);
  endtask : rd_byte
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial begin
    repeat (80000) @(posedge i_clk);
    err_count++;
    $display("Watchdog expired");
    stop_test();
  end
  initial begin
    i_rst_n = 1'b0;
    temp = 16'h1980;
    cfg = 16'h8C05;
    for (int i = 0; i < CLK_REGS; i++) clkv[8*i +: 8] = 8'h20 + 8'(i);
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    check("busy idle", {7'h0, o_busy}, 8'h00);
    m.start_cond();
    wr_byte(ADDR_WR, a);
    check("addr ack", {7'h0, a}, 8'h01);
    wr_byte(CMD_READ_TEMP, a);
    check("cmd ack", {7'h0, a}, 8'h01);
    check("command", o_command, CMD_READ_TEMP);
    check("busy", {7'h0, o_busy}, 8'h01);
    m.start_cond();
    wr_byte(ADDR_RD, a);
    check("read ack", {7'h0, a}, 8'h01);
    rd_byte(1'b1, q);
    check("temp high", q, temp[15:8]);
    rd_byte(1'b0, q);
    check("temp low", q, temp[7:0]);
    m.start_cond();
    wr_byte(ADDR_WR, a);
    wr_byte(CMD_ACCESS_CLOCK, a);
    wr_byte({5'h00, CLK_ADDR_MINUTES}, a);
    check("pointer ack", {7'h0, a}, 8'h01);
    m.start_cond();
    wr_byte(ADDR_RD, a);
    for (int k = 0; k < CLK_REGS; k++) begin
      rd_byte(k < CLK_REGS - 1, q);
      check("clock byte", q, clkv[8*((k+1)%CLK_REGS) +: 8]);
    end
    m.start_cond();
    wr_byte(ADDR_WR, a);
    wr_byte(CMD_ACCESS_CONFIG, a);
    m.start_cond();
    wr_byte(ADDR_RD, a);
    rd_byte(1'b1, q);
    check("config high", q, cfg[15:8]);
    rd_byte(1'b0, q);
    check("config low", q, cfg[7:0]);
    m.stop_cond();
    repeat (8) @(posedge i_clk);
    check("busy stop", {7'h0, o_busy}, 8'h00);
    check("command stop", o_command, 8'h00);
    m.start_cond();
    wr_byte(ADDR_WR, a);
    wr_byte(CMD_READ_TEMP, a);
    m.start_cond();
    wr_byte(ADDR_RD, a);
    rd_byte(1'b0, q);
    check("temp only", q, temp[15:8]);
    m.stop_cond();
    m.start_cond();
    wr_byte(ADDR_RD, a);
    rd_byte(1'b0, q);
    check("no command", q, 8'hFF);
    m.stop_cond();
    m.start_cond();
    wr_byte(8'h90, a);
    check("foreign addr", {7'h0, a}, 8'h00);
    m.stop_cond();
    m.start_cond();
    wr_byte(ADDR_WR, a);
    wr_byte(CMD_ACCESS_CLOCK, a);
    wr_byte(8'h09, a);
    m.start_cond();
    wr_byte(ADDR_RD, a);
    rd_byte(1'b0, q);
    check("pointer range", q, clkv[7:0]);
    m.stop_cond();
    stop_test();
  end
endmodule : tcrd_top_tb
